// File: include/ltig_pkg.sv
/*
  Package of the low-threshold interrupt and pin configuration block:
  register indices, field positions, reset values, codes and the
  packed carriers of the register bus.
  Assumes an APB master with 32-bit data and byte-lane strobes.
*/
package ltig_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned STAGES     = 12;
  localparam int unsigned REG_W      = 16;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned STRB_W     = 4;
  localparam int unsigned IRQ_W      = 13;

  // ---------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_RECAL_CTRL  = 12'h004;
  localparam logic [ADDR_W-1:0] IDX_LOW_IRQ_PIN = 12'h005;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS  = 12'h008;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK    = 12'h009;
  localparam logic [ADDR_W-1:0] IDX_PIN_CTRL    = 12'h00A;
  localparam int unsigned       IDX_SHIFT       = 2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned FP_RECAL_LSB   = 0;
  localparam int unsigned FP_RECAL_W     = 10;
  localparam int unsigned LP_RECAL_LSB   = 10;
  localparam int unsigned LP_RECAL_W     = 6;
  localparam int unsigned STAGE_EN_LSB   = 0;
  localparam int unsigned PIN_SETUP_LSB  = 12;
  localparam int unsigned PIN_TRIG_LSB   = 14;
  localparam int unsigned IRQ_PIN_BIT    = 12;
  localparam int unsigned PIN_ASSERT_BIT = 0;
  localparam int unsigned PIN_LEVEL_BIT  = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [FP_RECAL_W-1:0] FP_RECAL_RST  = 10'h3FF;
  localparam logic [LP_RECAL_W-1:0] LP_RECAL_RST  = 6'h3F;
  localparam logic [REG_W-1:0]      LOW_IRQ_RST   = 16'h0000;
  localparam logic [IRQ_W-1:0]      IRQ_MASK_RST  = 13'h1FFF;
  localparam logic [IRQ_W-1:0]      IRQ_STAT_RST  = 13'h0000;
  localparam logic [DATA_W-1:0]     RDATA_RST     = 32'h00000000;

  // ---------------------------------------------------------------
  // Pin role and input trigger codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PIN_OFF      = 2'b00,
    PIN_INPUT    = 2'b01,
    PIN_OUT_LOW  = 2'b10,
    PIN_OUT_HIGH = 2'b11
  } ltig_pin_setup_t;

  typedef enum logic [1:0] {
    TRIG_LEVEL_LOW  = 2'b00,
    TRIG_RISE       = 2'b01,
    TRIG_FALL       = 2'b10,
    TRIG_LEVEL_HIGH = 2'b11
  } ltig_pin_trig_t;

  // ---------------------------------------------------------------
  // Bus carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata;
    logic [STRB_W-1:0]   pstrb;
  } ltig_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
  } ltig_apb_rsp_t;

endpackage : ltig_pkg

// File: verilog/ltig_ctrl.sv
/*
  Low-threshold interrupt enables, proximity recalibration times and
  general-purpose pin configuration, reached over APB.
  Assumes all inputs synchronous to ref_clk; the threshold compare
  logic drives one level per conversion stage while its low threshold
  is exceeded; the pad combines pin output and enable.
*/
// The APB interface to the registers is this design's own decision.
// Function
// - Ten-bit full-power recal time, reset all ones
// - Six-bit low-power recal time, reset all ones
// - Twelve per-stage low-threshold enables, reset zero
// - Enabled low-threshold crossing asserts active-low interrupt
// - Pin setup 00 disabled, 01 input
// - Pin setup 10 active-low, 11 active-high output
// - Input trigger: low, rise, fall, high
`timescale 1ns/1ps

module ltig_ctrl #(
  parameter int unsigned N_STAGES = ltig_pkg::STAGES
) (
  input  wire logic                         ref_clk,
  input  wire logic                         nrst,
  input  wire ltig_pkg::ltig_apb_req_t      apb_req,
  output      ltig_pkg::ltig_apb_rsp_t      apb_rsp,
  input  wire logic [N_STAGES-1:0]          stage_low_exceeded,
  input  wire logic                         gpio_in,
  output      logic                         gpio_out,
  output      logic                         gpio_oe,
  output      logic [ltig_pkg::FP_RECAL_W-1:0] full_power_recal_time,
  output      logic [ltig_pkg::LP_RECAL_W-1:0] low_power_recal_time,
  output      logic [N_STAGES-1:0]          stage_low_irq_en,
  output      logic                         irq,
  output      logic                         int_n
);
  import ltig_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [FP_RECAL_W-1:0] fp_recal;
    logic [LP_RECAL_W-1:0] lp_recal;
    logic [N_STAGES-1:0]   stage_en;
    ltig_pin_setup_t       pin_setup;
    ltig_pin_trig_t        pin_trig;
    logic [IRQ_W-1:0]      irq_status;
    logic [IRQ_W-1:0]      irq_mask;
    logic                  pin_assert;
    logic                  pin_prev;
    logic                  pin_out;
    logic                  pin_oe;
    logic [DATA_W-1:0]     rdata;
    logic                  slverr;
  } ltig_state_t;

  ltig_state_t st;
  ltig_state_t next_st;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic              setup_phase;
  logic              access_done;
  logic [ADDR_W-1:0] idx;
  logic              aligned;
  logic              hit_recal;
  logic              hit_low;
  logic              hit_stat;
  logic              hit_mask;
  logic              hit_pin;
  logic              mapped;

  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable;
  assign idx         = apb_req.paddr >> IDX_SHIFT;
  assign aligned     = (apb_req.paddr[IDX_SHIFT-1:0] == '0);
  assign hit_recal   = aligned & (idx == IDX_RECAL_CTRL);
  assign hit_low     = aligned & (idx == IDX_LOW_IRQ_PIN);
  assign hit_stat    = aligned & (idx == IDX_IRQ_STATUS);
  assign hit_mask    = aligned & (idx == IDX_IRQ_MASK);
  assign hit_pin     = aligned & (idx == IDX_PIN_CTRL);
  assign mapped      = hit_recal | hit_low | hit_stat | hit_mask | hit_pin;

  // ---------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------
  logic [REG_W-1:0] recal_view;
  logic [REG_W-1:0] low_view;
  logic [REG_W-1:0] pin_view;

  assign recal_view = {st.lp_recal, st.fp_recal};
  assign low_view   = {st.pin_trig, st.pin_setup, st.stage_en};
  always_comb begin
    pin_view                 = '0;
    pin_view[PIN_ASSERT_BIT] = st.pin_assert;
    pin_view[PIN_LEVEL_BIT]  = gpio_in;
  end

  // ---------------------------------------------------------------
  // Interrupt sources
  // ---------------------------------------------------------------
  logic [N_STAGES-1:0] stage_set;
  logic                pin_event;
  logic [IRQ_W-1:0]    irq_set;

  for (genvar g = 0; g < N_STAGES; g++) begin : g_stage
    // A disabled stage is no interrupt source at all.
    assign stage_set[g] = st.stage_en[g] & stage_low_exceeded[g];
  end

  always_comb begin
    pin_event = 1'b0;
    if (st.pin_setup == PIN_INPUT) begin
      unique case (st.pin_trig)
        TRIG_LEVEL_LOW:  pin_event = ~gpio_in;
        TRIG_RISE:       pin_event = gpio_in & ~st.pin_prev;
        TRIG_FALL:       pin_event = ~gpio_in & st.pin_prev;
        TRIG_LEVEL_HIGH: pin_event = gpio_in;
      endcase
    end
  end

  always_comb begin
    irq_set              = '0;
    irq_set[N_STAGES-1:0] = stage_set;
    irq_set[IRQ_PIN_BIT] = pin_event;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic [REG_W-1:0] wmask;
  logic [REG_W-1:0] wval_recal;
  logic [REG_W-1:0] wval_low;
  logic [REG_W-1:0] wval_pin;
  logic [IRQ_W-1:0] stat_clr;
  logic             wr;

  always_comb begin
    wmask      = {{(DATA_W/STRB_W){apb_req.pstrb[1]}}, {(DATA_W/STRB_W){apb_req.pstrb[0]}}};
    wr         = access_done & apb_req.pwrite;
    wval_recal = (recal_view & ~wmask) | (apb_req.pwdata[REG_W-1:0] & wmask);
    wval_low   = (low_view & ~wmask) | (apb_req.pwdata[REG_W-1:0] & wmask);
    wval_pin   = (pin_view & ~wmask) | (apb_req.pwdata[REG_W-1:0] & wmask);
    stat_clr   = '0;
    next_st    = st;

    if (wr && hit_recal) begin
      next_st.fp_recal = wval_recal[FP_RECAL_LSB +: FP_RECAL_W];
      next_st.lp_recal = wval_recal[LP_RECAL_LSB +: LP_RECAL_W];
    end
    if (wr && hit_low) begin
      next_st.stage_en  = wval_low[STAGE_EN_LSB +: N_STAGES];
      next_st.pin_setup = ltig_pin_setup_t'(
        wval_low[PIN_SETUP_LSB +: $bits(ltig_pin_setup_t)]);
      next_st.pin_trig  = ltig_pin_trig_t'(
        wval_low[PIN_TRIG_LSB +: $bits(ltig_pin_trig_t)]);
    end
    if (wr && hit_mask) begin
      next_st.irq_mask = (st.irq_mask & ~wmask[IRQ_W-1:0])
                       | (apb_req.pwdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end
    if (wr && hit_pin) begin
      next_st.pin_assert = wval_pin[PIN_ASSERT_BIT];
    end

    // Reading the status register clears it; a new event in the same
    // cycle wins over the clear, but a pin edge event set in the setup cycle is cleared unread.
    if (access_done && !apb_req.pwrite && hit_stat) begin
      stat_clr = '1;
    end
    next_st.irq_status = (st.irq_status & ~stat_clr) | irq_set;

    // Read data and error are captured in the setup cycle so that the
    // zero-wait access phase presents flop outputs.
    if (setup_phase) begin
      next_st.slverr = ~mapped;
      next_st.rdata  = RDATA_RST;
      if (!apb_req.pwrite) begin
        if (hit_recal) next_st.rdata[REG_W-1:0] = recal_view;
        if (hit_low)   next_st.rdata[REG_W-1:0] = low_view;
        if (hit_stat)  next_st.rdata[IRQ_W-1:0] = st.irq_status;
        if (hit_mask)  next_st.rdata[IRQ_W-1:0] = st.irq_mask;
        if (hit_pin)   next_st.rdata[REG_W-1:0] = pin_view;
      end
    end

    next_st.pin_prev = gpio_in;
    unique case (next_st.pin_setup)
      PIN_OFF, PIN_INPUT: begin
        next_st.pin_oe  = 1'b0;
        next_st.pin_out = 1'b0;
      end
      PIN_OUT_LOW: begin
        next_st.pin_oe  = 1'b1;
        next_st.pin_out = ~next_st.pin_assert;
      end
      PIN_OUT_HIGH: begin
        next_st.pin_oe  = 1'b1;
        next_st.pin_out = next_st.pin_assert;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st.fp_recal   <= FP_RECAL_RST;
      st.lp_recal   <= LP_RECAL_RST;
      st.stage_en   <= LOW_IRQ_RST[STAGE_EN_LSB +: N_STAGES];
      st.pin_setup  <= PIN_OFF;
      st.pin_trig   <= TRIG_LEVEL_LOW;
      st.irq_status <= IRQ_STAT_RST;
      st.irq_mask   <= IRQ_MASK_RST;
      st.pin_assert <= 1'b0;
      st.pin_prev   <= 1'b0;
      st.pin_out    <= 1'b0;
      st.pin_oe     <= 1'b0;
      st.rdata      <= RDATA_RST;
      st.slverr     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Zero wait states: every access completes at its first access-phase edge.
  assign apb_rsp = '{prdata:  st.rdata,
                     pready:  1'b1,
                     pslverr: st.slverr & access_done};

  assign full_power_recal_time = st.fp_recal;
  assign low_power_recal_time  = st.lp_recal;
  assign stage_low_irq_en      = st.stage_en;
  assign gpio_out              = st.pin_out;
  assign gpio_oe               = st.pin_oe;

  // Every pending, unmasked source keeps the interrupt asserted.
  assign irq   = |(st.irq_status & st.irq_mask);
  assign int_n = ~irq;

endmodule : ltig_ctrl

// File: tb/ltig_pin_model.sv
/* Pad model of the general-purpose pin.
   Assumes a board pull-up that holds the pin high when undriven. */
`timescale 1ns/1ps
module ltig_pin_model (
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic ext_drive,
  input  wire logic ext_val,
  output      logic pin
);
  // The block wins the pin while it drives; else the far side or the pull-up.
  assign pin = gpio_oe ? gpio_out : (ext_drive ? ext_val : 1'b1);
endmodule : ltig_pin_model

// File: tb/ltig_ctrl_checker.sv
/* Concurrent checks on the ports of ltig_ctrl.
   Assumes the bind at the foot reaches every ltig_ctrl instance. */
`timescale 1ns/1ps
module ltig_ctrl_checker import ltig_pkg::*; #(
  parameter int unsigned N_STAGES = STAGES
) (
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire ltig_apb_req_t         apb_req,
  input wire ltig_apb_rsp_t         apb_rsp,
  input wire logic [N_STAGES-1:0]   stage_low_exceeded,
  input wire logic                  gpio_in,
  input wire logic                  gpio_out,
  input wire logic                  gpio_oe,
  input wire logic [FP_RECAL_W-1:0] full_power_recal_time,
  input wire logic [LP_RECAL_W-1:0] low_power_recal_time,
  input wire logic [N_STAGES-1:0]   stage_low_irq_en,
  input wire logic                  irq,
  input wire logic                  int_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire wr    = apb_req.psel & apb_req.penable & apb_req.pwrite & (apb_req.pstrb[1:0] == 2'h3);
  wire wr_rc = wr & (apb_req.paddr == 12'h010);
  wire wr_ip = wr & (apb_req.paddr == 12'h014);

  irq_pair_a: assert property (int_n == !irq)
    else $error("int_n not inverse of irq");
  pready_a: assert property (apb_rsp.pready)
    else $error("pready low");
  fp_write_a: assert property (
    wr_rc |=> full_power_recal_time == $past(apb_req.pwdata[9:0]))
    else $error("full power time not written");
  lp_write_a: assert property (
    wr_rc |=> low_power_recal_time == $past(apb_req.pwdata[15:10]))
    else $error("low power time not written");
  en_write_a: assert property (
    wr_ip |=> stage_low_irq_en == $past(apb_req.pwdata[11:0]))
    else $error("stage enables not written");
  out_en_a: assert property (wr_ip && apb_req.pwdata[13] |=> gpio_oe)
    else $error("pin not driven in output role");
  pin_off_a: assert property (wr_ip && !apb_req.pwdata[13] |=> !gpio_oe)
    else $error("pin driven outside output role");
  recal_hold_a: assert property (
    !wr_rc |=> $stable(full_power_recal_time) && $stable(low_power_recal_time))
    else $error("recal time changed without write");
endmodule : ltig_ctrl_checker

bind ltig_ctrl ltig_ctrl_checker #(.N_STAGES(N_STAGES)) checker_i (.*);

// File: tb/ltig_ctrl_tb.sv
/* Self-checking bench of ltig_ctrl over APB.
   Assumes the checker is bound and the pad model closes the pin loop. */
`timescale 1ns/1ps
module ltig_ctrl_tb;
  import ltig_pkg::*;
  logic ref_clk, nrst, ext_drive, ext_val, pin, gout, goe, irq, int_n, e;
  ltig_apb_req_t req;
  ltig_apb_rsp_t rsp;
  logic [11:0]   exc, sen;
  logic [9:0]    fpt;
  logic [5:0]    lpt;
  logic [31:0]   q;
  logic [3:0]    s0 = 4'b0101;
  int            bad_count, checks_done, n;
  localparam logic [11:0] A_RC = IDX_RECAL_CTRL << IDX_SHIFT;
  localparam logic [11:0] A_IP = IDX_LOW_IRQ_PIN << IDX_SHIFT;
  localparam logic [11:0] A_ST = IDX_IRQ_STATUS << IDX_SHIFT;
  localparam logic [11:0] A_MK = IDX_IRQ_MASK << IDX_SHIFT;
  localparam logic [11:0] A_PC = IDX_PIN_CTRL << IDX_SHIFT;

  ltig_ctrl DUT (.ref_clk(ref_clk), .nrst(nrst), .apb_req(req), .apb_rsp(rsp),
    .stage_low_exceeded(exc), .gpio_in(pin), .gpio_out(gout), .gpio_oe(goe),
    .full_power_recal_time(fpt), .low_power_recal_time(lpt),
    .stage_low_irq_en(sen), .irq(irq), .int_n(int_n));
  ltig_pin_model pad (.gpio_out(gout), .gpio_oe(goe), .ext_drive(ext_drive),
    .ext_val(ext_val), .pin(pin));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task conclude;
    $display("counts: mismatches %0d, comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hF};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 50) begin
      bad_count++;
      conclude();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  initial begin
    req       = '0;
    exc       = '0;
    ext_drive = 1'b0;
    ext_val   = 1'b0;
    nrst      = 1'b0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(A_RC, 32'h0000FFFF);
    rd(A_IP, 32'h0);
    chk(32'(goe), 32'h0);
    chk(32'(int_n), 32'h1);
    apb(1'b1, A_RC, 32'h0000A955);
    rd(A_RC, 32'h0000A955);
    chk(32'(fpt), 32'h155);
    chk(32'(lpt), 32'h2A);
    $display("test recal done");
    for (n = 0; n < 12; n++) begin
      apb(1'b1, A_IP, 32'(1 << n));
      exc <= ~(12'h1 << n);
      repeat (2) @(posedge ref_clk);
      chk(32'(int_n), 32'h1);
      exc <= 12'h1 << n;
      repeat (2) @(posedge ref_clk);
      chk(32'(int_n), 32'h0);
      exc <= '0;
      rd(A_ST, 32'(1 << n));
      chk(32'(sen), 32'(1 << n));
      @(posedge ref_clk);
      chk(32'(irq), 32'h0);
    end
    // Stage eleven is still enabled: a masked event is held but kept off the output.
    apb(1'b1, A_MK, 32'h0);
    exc <= 12'h800;
    repeat (2) @(posedge ref_clk);
    chk(32'(int_n), 32'h1);
    apb(1'b1, A_MK, 32'h1FFF);
    @(posedge ref_clk);
    chk(32'(int_n), 32'h0);
    exc <= '0;
    rd(A_ST, 32'h800);
    $display("test stage interrupts done");
    apb(1'b1, A_PC, 32'h1);
    for (n = 0; n < 4; n++) begin
      apb(1'b1, A_IP, 32'(n << 12));
      @(posedge ref_clk);
      chk(32'(goe), 32'(n >= 2));
      if (n >= 2) chk(32'(gout), 32'(n == 3));
    end
    apb(1'b1, A_PC, 32'h0);
    @(posedge ref_clk);
    chk(32'(gout), 32'h0);
    $display("test pin output done");
    for (n = 0; n < 4; n++) begin
      ext_drive <= 1'b1;
      ext_val <= s0[n];
      apb(1'b1, A_IP, 32'({n[1:0], 2'b01, 12'h000}));
      apb(1'b0, A_ST, 32'h0);
      rd(A_ST, 32'h0);
      ext_val <= ~s0[n];
      repeat (2) @(posedge ref_clk);
      chk(32'(int_n), 32'h0);
      rd(A_ST, 32'h1000);
      rd(A_PC, 32'({~s0[n], 1'b0}));
    end
    $display("test pin trigger done");
    apb(1'b0, 12'h00C, 32'h0);
    chk(32'(e), 32'h1);
    chk(q, 32'h0);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    chk(32'(int_n), 32'h1);
    chk(32'(goe), 32'h0);
    rd(A_RC, 32'h0000FFFF);
    rd(A_IP, 32'h0);
    $display("test error and reset done");
    conclude();
  end
endmodule : ltig_ctrl_tb
